//--- core/scw_pkg.sv
// Package for the transceiver core word mapper: word layout, register map,
// modes, line-side carrier and timing constants.
// Assumes a single 20 MHz bus clock; every user imports nothing and names scw_pkg:: explicitly.
package scw_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOCK_TIME_NS  = 1000;  // Least settle time before lock is reported
    localparam logic [4:0] LOCK_CYC =
        5'((LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Core word layout (double-width)
    localparam int WORD_W      = 80;
    localparam int PAY_W       = 66;
    localparam int BIT_MARK_HI = 79;
    localparam int BIT_DESKEW  = 78;
    localparam int BIT_SNAP    = 77;
    localparam int USED_HI     = 77;
    localparam int USED_LO     = 73;
    localparam int BIT_EMPTY   = 72;
    localparam int BIT_PFULL   = 71;
    localparam int BIT_SYNC    = 69;
    localparam int BIT_VALID   = 68;
    localparam int PAY_HI_TOP  = 66;
    localparam int PAY_HI_BOT  = 40;
    localparam int BIT_MARK_LO = 39;
    localparam int PAY_LO_TOP  = 38;
    localparam logic MARK_HI_VAL = 1'b1;
    localparam logic MARK_LO_VAL = 1'b0;

    // Word qualifier cadence
    localparam logic [5:0] QUAL_LAST = 6'h20;  // Phase 32 of 0..32

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h04;
    localparam logic [7:0] OFS_SYNTH    = 8'h08;
    localparam logic [7:0] OFS_TXCNT_LO = 8'h10;
    localparam logic [7:0] OFS_TXCNT_HI = 8'h14;
    localparam logic [7:0] OFS_RXCNT_LO = 8'h18;
    localparam logic [7:0] OFS_RXCNT_HI = 8'h1c;

    // Field positions
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_FEC     = 2;
    localparam int CTRL_DRV     = 3;
    localparam int STAT_LOCK    = 0;
    localparam int STAT_REJECT  = 1;
    localparam int STAT_QUALERR = 2;
    localparam int STAT_CFGERR  = 3;
    localparam int SYN_FREQ_LO  = 0;
    localparam int SYN_FREQ_HI  = 9;
    localparam int SYN_REF_LO   = 12;
    localparam int SYN_REF_HI   = 14;
    localparam int SYN_DIV_LO   = 16;
    localparam int SYN_DIV_HI   = 19;

    // Synthesizer limits and reset values
    localparam logic [9:0] FREQ_MIN = 10'h064;
    localparam logic [9:0] FREQ_MAX = 10'h3e8;
    localparam logic [9:0] FREQ_RST = 10'h190;
    localparam logic [2:0] REF_NUM  = 3'h5;
    localparam logic [3:0] DIV_RST  = 4'h1;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {MODE_DUPLEX, MODE_TX_ONLY, MODE_RX_ONLY, MODE_SYNTH} scw_mode_e;

    // Line side of the receive path
    typedef struct packed {
        logic [PAY_W-1:0] payload;
        logic             fec_valid;
        logic             deskew;
        logic             sync;
        logic [4:0]       fifo_stat;
        logic             rxf_empty;
        logic             rxf_pfull;
    } scw_rx_line_s;

endpackage : scw_pkg

//--- core/scw_word_map.sv
// Core word mapper of one transceiver channel: packs and unpacks the 80-bit
// words, keeps snapshot counters, models the synthesizer configuration and
// simplex termination, and exposes control and status over AHB-Lite.
// Assumes fabric and line side run on hclk; reference presence levels are asynchronous.
`timescale 1ns/1ns
module scw_word_map (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic [79:0]           tx_word,
    output logic [79:0]                tx_lane_word,
    output logic [65:0]                tx_payload,
    input  wire scw_pkg::scw_rx_line_s rx_line,
    output logic [79:0]                rx_word,
    input  wire logic [4:0]            synth_ref_input,
    output logic                       synth_out_primary,
    output logic                       synth_out_half,
    output logic                       synth_lock,
    output logic                       dep_chan_rst_n,
    output logic                       tx_drv_en,
    output logic                       tx_pwr_dn,
    output logic                       rx_pwr_dn,
    output logic                       fec_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic               a_act;
        logic               a_wr;
        logic [7:0]         a_addr;
        scw_pkg::scw_mode_e mode;
        logic               configured;
        logic               fec_en;
        logic               drv_en;
        logic               reject;
        logic               qual_err;
        logic               cfg_err;
        logic [9:0]         freq;
        logic [2:0]         ref_sel;
        logic [3:0]         div;
        logic [3:0]         div_cnt;
        logic               half_tgl;
        logic               prim;
        logic               half;
        logic [4:0]         lock_cnt;
        logic               locked;
        logic [5:0]         qual_phase;
        logic               snap_d;
        logic [63:0]        tx_cnt;
        logic [63:0]        rx_cnt;
        logic [31:0]        txh_lo;
        logic [31:0]        txh_hi;
        logic [31:0]        rxh_lo;
        logic [31:0]        rxh_hi;
        logic [79:0]        tx_lane;
        logic [65:0]        tx_pay;
        logic [79:0]        rx_word;
        logic [4:0]         ref_s1;
        logic [4:0]         ref_s2;
        logic [7:0]         chk_prim_n;
        logic [6:0]         chk_half_n;
    } scw_state_s;

    scw_state_s         s;
    scw_state_s         n;
    scw_pkg::scw_mode_e wmode;
    logic               tx_act;
    logic               rx_act;
    logic               snap;
    logic               ref_ok;

    assign wmode  = scw_pkg::scw_mode_e'(hwdata[scw_pkg::CTRL_MODE_HI:scw_pkg::CTRL_MODE_LO]);
    assign tx_act = (s.mode == scw_pkg::MODE_DUPLEX) || (s.mode == scw_pkg::MODE_TX_ONLY);
    assign rx_act = (s.mode == scw_pkg::MODE_DUPLEX) || (s.mode == scw_pkg::MODE_RX_ONLY);
    assign snap   = tx_word[scw_pkg::BIT_SNAP];
    assign ref_ok = s.ref_s2[s.ref_sel];

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        n      = s;
        n.prim = 1'b0;
        n.half = 1'b0;

        // Reference presence levels cross in through two flops
        n.ref_s1 = synth_ref_input;
        n.ref_s2 = s.ref_s1;

        // Transmit word: tags forced, payload unpacked, line silent when unused
        n.tx_lane = '0;
        n.tx_pay  = '0;
        if (tx_act) begin
            n.tx_lane                        = tx_word;
            n.tx_lane[scw_pkg::BIT_MARK_HI]  = scw_pkg::MARK_HI_VAL;
            n.tx_lane[scw_pkg::BIT_MARK_LO]  = scw_pkg::MARK_LO_VAL;
            n.tx_pay = {tx_word[scw_pkg::PAY_HI_TOP:scw_pkg::PAY_HI_BOT],
                        tx_word[scw_pkg::PAY_LO_TOP:0]};
        end

        // Receive word: packed from the line, terminated when the side is unused
        n.rx_word = '0;
        if (rx_act) begin
            n.rx_word[scw_pkg::BIT_MARK_HI]                   = scw_pkg::MARK_HI_VAL;
            n.rx_word[scw_pkg::BIT_DESKEW]                    = rx_line.deskew;
            n.rx_word[scw_pkg::USED_HI:scw_pkg::USED_LO]      = rx_line.fifo_stat;
            n.rx_word[scw_pkg::BIT_EMPTY]                     = rx_line.rxf_empty;
            n.rx_word[scw_pkg::BIT_PFULL]                     = rx_line.rxf_pfull;
            n.rx_word[scw_pkg::BIT_SYNC]                      = rx_line.sync;
            n.rx_word[scw_pkg::BIT_VALID]                     = rx_line.fec_valid;
            n.rx_word[scw_pkg::PAY_HI_TOP:scw_pkg::PAY_HI_BOT] = rx_line.payload[65:39];
            n.rx_word[scw_pkg::BIT_MARK_LO]                   = scw_pkg::MARK_LO_VAL;
            n.rx_word[scw_pkg::PAY_LO_TOP:0]                  = rx_line.payload[38:0];
        end

        // Running word counters
        if (tx_act && tx_word[scw_pkg::BIT_VALID]) begin
            n.tx_cnt = s.tx_cnt + 64'h1;
        end
        if (rx_act && rx_line.fec_valid) begin
            n.rx_cnt = s.rx_cnt + 64'h1;
        end

        // Holding registers track while low, latch on the rising edge, then freeze
        n.snap_d = snap;
        if (!snap || !s.snap_d) begin
            n.txh_lo = s.tx_cnt[31:0];
            n.txh_hi = s.tx_cnt[63:32];
            n.rxh_lo = s.rx_cnt[31:0];
            n.rxh_hi = s.rx_cnt[63:32];
        end

        // Synthesizer divider; half output fires on every second primary pulse
        if (s.mode == scw_pkg::MODE_SYNTH) begin
            if (s.div_cnt >= s.div) begin
                n.div_cnt  = 4'h0;
                n.prim     = 1'b1;
                n.half_tgl = ~s.half_tgl;
                n.half     = s.half_tgl;
            end else begin
                n.div_cnt = s.div_cnt + 4'h1;
            end
        end
        n.chk_prim_n = s.chk_prim_n + {7'h0, s.prim};
        n.chk_half_n = s.chk_half_n + {6'h0, s.half};

        // Lock needs the selected reference present for the full settle time
        if ((s.mode == scw_pkg::MODE_SYNTH) && ref_ok) begin
            if (s.lock_cnt != scw_pkg::LOCK_CYC) begin
                n.lock_cnt = s.lock_cnt + 5'h1;
            end
            n.locked = (s.lock_cnt == scw_pkg::LOCK_CYC);
        end else begin
            n.lock_cnt = 5'h0;
            n.locked   = 1'b0;
        end

        // Bus address phase: single whole-word transfers only
        n.a_act = hsel && htrans[1] && hready && (hsize == scw_pkg::HSIZE_WORD);
        if (n.a_act) begin
            n.a_wr   = hwrite;
            n.a_addr = haddr[7:0];
        end

        // Bus write data phase
        if (s.a_act && s.a_wr) begin
            case (s.a_addr)
                scw_pkg::OFS_CTRL: begin
                    // Synthesizer mode is fixed until reset once either side of it was chosen
                    if (s.configured && (wmode != s.mode) &&
                        ((wmode == scw_pkg::MODE_SYNTH) || (s.mode == scw_pkg::MODE_SYNTH))) begin
                        n.reject = 1'b1;
                    end else begin
                        n.mode       = wmode;
                        n.configured = 1'b1;
                    end
                    n.fec_en = hwdata[scw_pkg::CTRL_FEC];
                    n.drv_en = hwdata[scw_pkg::CTRL_DRV];
                end
                scw_pkg::OFS_STAT: begin
                    // Write one to clear
                    if (hwdata[scw_pkg::STAT_REJECT]) begin
                        n.reject = 1'b0;
                    end
                    if (hwdata[scw_pkg::STAT_QUALERR]) begin
                        n.qual_err = 1'b0;
                    end
                    if (hwdata[scw_pkg::STAT_CFGERR]) begin
                        n.cfg_err = 1'b0;
                    end
                end
                scw_pkg::OFS_SYNTH: begin
                    // Out-of-range values are refused and flagged, old setting kept
                    if ((hwdata[scw_pkg::SYN_FREQ_HI:scw_pkg::SYN_FREQ_LO] >= scw_pkg::FREQ_MIN) &&
                        (hwdata[scw_pkg::SYN_FREQ_HI:scw_pkg::SYN_FREQ_LO] <= scw_pkg::FREQ_MAX) &&
                        (hwdata[scw_pkg::SYN_REF_HI:scw_pkg::SYN_REF_LO] < scw_pkg::REF_NUM)) begin
                        n.freq     = hwdata[scw_pkg::SYN_FREQ_HI:scw_pkg::SYN_FREQ_LO];
                        n.ref_sel  = hwdata[scw_pkg::SYN_REF_HI:scw_pkg::SYN_REF_LO];
                        n.div      = hwdata[scw_pkg::SYN_DIV_HI:scw_pkg::SYN_DIV_LO];
                        n.lock_cnt = 5'h0;
                        n.locked   = 1'b0;
                    end else begin
                        n.cfg_err = 1'b1;
                    end
                end
                default: begin
                    // Unmapped or read-only offsets ignore writes
                end
            endcase
        end

        // Qualifier cadence runs free from reset; a miss is sticky and beats a clear
        n.qual_phase = (s.qual_phase == scw_pkg::QUAL_LAST) ? 6'h0 : s.qual_phase + 6'h1;
        if (tx_act && (tx_word[scw_pkg::BIT_VALID] != (s.qual_phase != scw_pkg::QUAL_LAST))) begin
            n.qual_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s      <= '0;
            s.freq <= scw_pkg::FREQ_RST;
            s.div  <= scw_pkg::DIV_RST;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus read mux; zero wait states so the answer sits in the data phase

    always_comb begin
        hrdata = 32'h0;
        if (s.a_act && !s.a_wr) begin
            case (s.a_addr)
                scw_pkg::OFS_CTRL:     hrdata = {28'h0, s.drv_en, s.fec_en, s.mode};
                scw_pkg::OFS_STAT:     hrdata = {28'h0, s.cfg_err, s.qual_err, s.reject, s.locked};
                scw_pkg::OFS_SYNTH:    hrdata = {12'h0, s.div, 1'b0, s.ref_sel, 2'h0, s.freq};
                scw_pkg::OFS_TXCNT_LO: hrdata = s.txh_lo;
                scw_pkg::OFS_TXCNT_HI: hrdata = s.txh_hi;
                scw_pkg::OFS_RXCNT_LO: hrdata = s.rxh_lo;
                scw_pkg::OFS_RXCNT_HI: hrdata = s.rxh_hi;
                default:               hrdata = 32'h0;
            endcase
        end
    end

    // Outputs
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign tx_lane_word      = s.tx_lane;
    assign tx_payload        = s.tx_pay;
    assign rx_word           = s.rx_word;
    assign synth_out_primary = s.prim;
    assign synth_out_half    = s.half;
    assign synth_lock        = s.locked;
    assign dep_chan_rst_n    = s.locked;
    assign tx_drv_en         = s.drv_en && (s.mode != scw_pkg::MODE_RX_ONLY) &&
                               (s.mode != scw_pkg::MODE_SYNTH);
    assign tx_pwr_dn         = (s.mode == scw_pkg::MODE_RX_ONLY);
    assign rx_pwr_dn         = (s.mode == scw_pkg::MODE_TX_ONLY) ||
                               (s.mode == scw_pkg::MODE_SYNTH);
    // Error correction only acts in duplex; simplex ignores the enable
    assign fec_active        = s.fec_en && (s.mode == scw_pkg::MODE_DUPLEX);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence snap_rise;
        !snap ##1 snap;
    endsequence

    chk_tx_tags: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_act |=> (tx_lane_word[79] == scw_pkg::MARK_HI_VAL) && (tx_lane_word[39] == scw_pkg::MARK_LO_VAL))
        else $error("transmit framing tags not inserted");

    chk_tx_payload: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_act |=> tx_payload == {$past(tx_word[66:40]), $past(tx_word[38:0])})
        else $error("transmit payload mapping wrong");

    chk_rx_valid: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_act |=> rx_word[68] == $past(rx_line.fec_valid))
        else $error("receive qualifier does not follow line valid");

    chk_rx_fifo_stat: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_act |=> rx_word[77:73] == $past(rx_line.fifo_stat))
        else $error("receive status field wrong");

    chk_rx_empty_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_act && rx_line.rxf_empty) |=> rx_word[72])
        else $error("receive empty flag missing");

    chk_rx_pfull_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_act && rx_line.rxf_pfull) |=> rx_word[71])
        else $error("receive partial full flag missing");

    chk_rx_deskew_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_act |=> rx_word[78] == $past(rx_line.deskew))
        else $error("receive deskew marker lost");

    chk_rx_sync_bit: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_act |=> rx_word[69] == $past(rx_line.sync))
        else $error("receive sync bit lost");

    chk_snap_capture: assert property (@(posedge hclk) disable iff (!hresetn)
        snap_rise |=> s.txh_lo == $past(s.tx_cnt[31:0]))
        else $error("snapshot did not capture counter");

    chk_snap_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
        snap_rise ##1 snap |=> $stable(s.txh_lo) && $stable(s.rxh_hi))
        else $error("holding register moved while frozen");

    chk_snap_track: assert property (@(posedge hclk) disable iff (!hresetn)
        !snap |=> s.rxh_lo == $past(s.rx_cnt[31:0]))
        else $error("holding register not tracking");

    chk_synth_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.mode == scw_pkg::MODE_SYNTH) |=> (s.mode == scw_pkg::MODE_SYNTH))
        else $error("left synthesizer mode");

    chk_synth_entry: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.configured && (s.mode != scw_pkg::MODE_SYNTH)) |=> (s.mode != scw_pkg::MODE_SYNTH))
        else $error("entered synthesizer mode after configuration");

    chk_half_rate: assert property (@(posedge hclk) disable iff (!hresetn)
        s.chk_half_n == s.chk_prim_n[7:1])
        else $error("half output not at half rate");

    chk_freq_range: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.freq >= scw_pkg::FREQ_MIN) && (s.freq <= scw_pkg::FREQ_MAX) && (s.ref_sel < scw_pkg::REF_NUM))
        else $error("synthesizer setting out of range");

    chk_synth_tx_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.mode == scw_pkg::MODE_SYNTH) |=> (tx_lane_word == 80'h0) && !tx_drv_en)
        else $error("synthesizer channel carries data");

    chk_simplex_term: assert property (@(posedge hclk) disable iff (!hresetn)
        (s.mode == scw_pkg::MODE_TX_ONLY) |=> (rx_word == 80'h0) && rx_pwr_dn)
        else $error("unused receive side not terminated");

    chk_lock_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        (synth_lock && !ref_ok) |=> !dep_chan_rst_n)
        else $error("dependent reset not asserted on lock loss");

endmodule : scw_word_map

//--- dv/scw_fabric_model.sv
// Fabric partner: builds the transmit word with the qualifier cadence.
// Assumes the bench supplies payload and marker bits on hclk.
`timescale 1ns/1ns
module scw_fabric_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [65:0] pay,
    input  wire logic [2:0]  mark,
    output logic [79:0]      tx_word
);
    logic [5:0] ph_reg;
    // Qualifier phase, free-running from reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ph_reg <= 6'h00;
        else ph_reg <= (ph_reg == 6'h20) ? 6'h00 : ph_reg + 6'h01;
    end
    // Tag positions hold wrong values so the device must overwrite them
    assign tx_word = {1'b0, mark[2:1], 7'h00, mark[0], ph_reg != 6'h20, 1'b0,
                      pay[65:39], 1'b1, pay[38:0]};
endmodule : scw_fabric_model

//--- dv/testbench.sv
// Self-checking bench for the core word mapper.
// Assumes a single hclk domain and the fabric partner model.
`timescale 1ns/1ns
module testbench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, r2;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, mark = 3'h0;
    logic [79:0] tx_word, tx_lane_word, rx_word, ptx;
    logic [65:0] pay = 66'h0, tx_payload;
    logic [4:0] synth_ref_input = 5'h00;
    logic [95:0] rv;
    scw_pkg::scw_rx_line_s rx_line = '0, prl;
    logic spri, shalf, synth_lock, dep_n, drv, tpd, rpd, fec;
    integer fails = 0, n_checks = 0, seed = 32'hfa08, k, np, nh;
    // Clock and the single-slave ready loop
    initial forever #25 hclk = ~hclk;
    assign hready = hreadyout;
    scw_fabric_model u_scw_fabric_model (.hclk(hclk), .hresetn(hresetn), .pay(pay),
        .mark(mark), .tx_word(tx_word));
    scw_word_map u_scw_word_map (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_word(tx_word),
        .tx_lane_word(tx_lane_word), .tx_payload(tx_payload), .rx_line(rx_line),
        .rx_word(rx_word), .synth_ref_input(synth_ref_input), .synth_out_primary(spri),
        .synth_out_half(shalf), .synth_lock(synth_lock), .dep_chan_rst_n(dep_n),
        .tx_drv_en(drv), .tx_pwr_dn(tpd), .rx_pwr_dn(rpd), .fec_active(fec));
    ////////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (fails == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task chk(input logic [79:0] g, input logic [79:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Waits for ready under a bound; a hung slave ends the run
    task rdy;
        integer t;
        t = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            if (++t > 50) begin
                fails++;
                test_done;
            end
            @(posedge hclk);
        end
    endtask : rdy
    // Each transfer starts just after a rising edge, whatever the caller waited on
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        rdy;
        r = hrdata;
        chk(80'(hresp), 80'h0);
    endtask : bus
    // Random words each cycle; outputs compared with last cycle's inputs
    task stream(input integer n);
        for (int j = 0; j < n; j++) begin
            @(posedge hclk);
            rv = {$random(seed), $random(seed), $random(seed)};
            pay <= rv[65:0]; rx_line <= rv[95:20]; mark <= rv[68:66];
            @(negedge hclk);
            if (j > 0) begin
                chk(tx_lane_word, {1'b1, ptx[78:40], 1'b0, ptx[38:0]});
                chk({14'h0, tx_payload}, {14'h0, ptx[66:40], ptx[38:0]});
                chk(rx_word, {1'b1, prl.deskew, prl.fifo_stat, prl.rxf_empty, prl.rxf_pfull,
                    1'b0, prl.sync, prl.fec_valid, 1'b0, prl.payload[65:39], 1'b0,
                    prl.payload[38:0]});
            end
            ptx = tx_word; prl = rx_line;
        end
    endtask : stream
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: duplex, receive-only, transmit-only, then synthesizer after a second reset
    initial begin
        repeat (4) @(posedge hclk);
        chk(80'({synth_lock, dep_n}), 80'h0);
        hresetn <= 1'b1;
        bus(1'b0, scw_pkg::OFS_SYNTH, 32'h0);
        chk(80'(r), 80'h10190);
        bus(1'b0, 8'h0c, 32'h0);
        chk(80'(r), 80'h0);
        stream(70);
        bus(1'b0, scw_pkg::OFS_STAT, 32'h0);
        chk(80'(r[2]), 80'h0);
        mark <= 3'h2;
        bus(1'b0, scw_pkg::OFS_TXCNT_LO, 32'h0);
        r2 = r;
        bus(1'b0, scw_pkg::OFS_TXCNT_LO, 32'h0);
        chk(80'(r), 80'(r2));
        mark <= 3'h0;
        bus(1'b0, scw_pkg::OFS_TXCNT_LO, 32'h0);
        r2 = r;
        bus(1'b0, scw_pkg::OFS_TXCNT_LO, 32'h0);
        chk(80'(r != r2), 80'h1);
        bus(1'b1, scw_pkg::OFS_CTRL, 32'he);
        @(posedge hclk);
        @(negedge hclk);
        chk(80'({tpd, drv, fec, rpd}), 80'h8);
        chk(tx_lane_word, 80'h0);
        // Transmit-only with drivers on; receive side must go quiet
        bus(1'b1, scw_pkg::OFS_CTRL, 32'h9);
        @(posedge hclk);
        @(negedge hclk);
        chk(80'({tpd, drv, fec, rpd}), 80'h5);
        chk(rx_word, 80'h0);
        bus(1'b1, scw_pkg::OFS_CTRL, 32'h3);
        bus(1'b0, scw_pkg::OFS_STAT, 32'h0);
        chk(80'(r[1]), 80'h1);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b1, scw_pkg::OFS_CTRL, 32'h3);
        synth_ref_input <= 5'h01;
        for (k = 0; synth_lock !== 1'b1 && k < 60; k++) @(negedge hclk);
        chk(80'({k > 20, synth_lock, dep_n}), 80'h7);
        chk(80'({rpd, drv}), 80'h2);
        chk(tx_lane_word, 80'h0);
        chk(rx_word, 80'h0);
        np = 0; nh = 0;
        repeat (40) begin
            @(negedge hclk);
            np += spri; nh += shalf;
        end
        chk(80'(np), 80'(2 * nh));
        chk(80'(np), 80'h14);
        bus(1'b1, scw_pkg::OFS_SYNTH, 32'h3e9);
        bus(1'b0, scw_pkg::OFS_STAT, 32'h0);
        chk(80'(r[3]), 80'h1);
        synth_ref_input <= 5'h00;
        for (k = 0; synth_lock !== 1'b0 && k < 10; k++) @(negedge hclk);
        chk(80'({synth_lock, dep_n}), 80'h0);
        test_done;
    end
endmodule : testbench
